// [shared/level_alarm_regs.svh]
`ifndef LEVEL_ALARM_REGS_SVH
`define LEVEL_ALARM_REGS_SVH
// Register indices as printed; the byte address on the bus is four times the index.
`define IDX_DETECT_PIN_CONTROL 12'h245
`define IDX_UPPER_THRESHOLD_LOW 12'h247
`define IDX_UPPER_THRESHOLD_HIGH 12'h248
`define IDX_LOWER_THRESHOLD_LOW 12'h249
`define IDX_LOWER_THRESHOLD_HIGH 12'h24A
`define IDX_DWELL_COUNT_LOW 12'h24B
`define IDX_DWELL_COUNT_HIGH 12'h24C
// Status register holding the live pin level and the dwell count.
`define IDX_DETECT_STATUS 12'h24D
// Control field positions.
`define CTRL_ENABLE_BIT 0
`define CTRL_FORCE_VALUE_BIT 2
`define CTRL_FORCE_BIT 3
// Writable bit masks; the other bits are reserved and read as zero.
`define CTRL_WRITE_MASK 8'h0D
`define THRESHOLD_HIGH_MASK 8'h1F
// Reset value shared by every field.
`define FIELD_RESET 8'h00
// Widths.
`define MAG_WIDTH 13
`define DWELL_WIDTH 16
// AXI responses.
`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2
`endif

// [shared/level_alarm_pkg.sv]
`default_nettype none
package level_alarm_pkg;
	// Magnitude and threshold type.
	typedef logic [12:0] magnitude_t;
	// Dwell counter type.
	typedef logic [15:0] dwell_t;
	// Read channel states of the bus slave.
	typedef enum logic [0:0] {RD_IDLE, RD_ANSWER} read_state_e;
	// Write channel states of the bus slave.
	typedef enum logic [0:0] {WR_IDLE, WR_ANSWER} write_state_e;
endpackage : level_alarm_pkg
`default_nettype wire

// [logic/dwell_timer.sv]
`include "level_alarm_regs.svh"
`default_nettype none
// Dwell timer and pin latch for one channel.
module dwell_timer
	import level_alarm_pkg::*;
(
	input wire logic clk,
	input wire logic rst,
	input wire logic ce,
	input wire logic active,
	input wire logic above_upper,
	input wire logic below_lower,
	input wire dwell_t load_value,
	output logic alarm,
	output dwell_t count
);
	// Next values for the latch and counter.
	logic next_alarm;
	dwell_t next_count;

	// Sets on an upper crossing and clears once the dwell has run out or detection is disabled.
	always_comb
	begin
		next_alarm = alarm;
		next_count = count;
		if (!active)
		begin
			// Disabled detection holds the latch clear.
			next_alarm = 1'b0;
			next_count = load_value;
		end
		else if (above_upper)
		begin
			// Crossing the upper threshold asserts at once.
			next_alarm = 1'b1;
			next_count = load_value;
		end
		else if (!below_lower)
		begin
			// At or above the lower threshold the dwell restarts.
			next_count = load_value;
		end
		else if (alarm)
		begin
			// Below the lower threshold the counter runs down.
			if (count == 16'h0000)
			begin
				next_alarm = 1'b0;
			end
			else
			begin
				next_count = count - 16'h0001;
			end
		end
	end

	// Registers the timer state.
	always_ff @(posedge clk)
	begin
		if (rst)
		begin
			alarm <= 1'b0;
			count <= 16'h0000;
		end
		else if (ce)
		begin
			alarm <= next_alarm;
			count <= next_count;
		end
	end
endmodule : dwell_timer
`default_nettype wire

// [logic/level_alarm_monitor.sv]
`include "level_alarm_regs.svh"
`default_nettype none
// Fast level alarm for one channel with an AXI4-Lite register slave.
module level_alarm_monitor
	import level_alarm_pkg::*;
(
	input wire logic CLK,
	input wire logic RST,
	input wire logic CE,
	input wire logic [12:0] MAGNITUDE,
	output logic LEVEL_ALARM_PIN,
	input wire logic [13:0] S_AXI_AWADDR,
	input wire logic S_AXI_AWVALID,
	output logic S_AXI_AWREADY,
	input wire logic [31:0] S_AXI_WDATA,
	input wire logic [3:0] S_AXI_WSTRB,
	input wire logic S_AXI_WVALID,
	output logic S_AXI_WREADY,
	output logic [1:0] S_AXI_BRESP,
	output logic S_AXI_BVALID,
	input wire logic S_AXI_BREADY,
	input wire logic [13:0] S_AXI_ARADDR,
	input wire logic S_AXI_ARVALID,
	output logic S_AXI_ARREADY,
	output logic [31:0] S_AXI_RDATA,
	output logic [1:0] S_AXI_RRESP,
	output logic S_AXI_RVALID,
	input wire logic S_AXI_RREADY
);
	// Software registers.
	logic [7:0] detect_pin_control;
	logic [7:0] upper_threshold_low;
	logic [7:0] upper_threshold_high;
	logic [7:0] lower_threshold_low;
	logic [7:0] lower_threshold_high;
	logic [7:0] dwell_count_low;
	logic [7:0] dwell_count_high;
	logic [7:0] next_detect_pin_control;
	logic [7:0] next_upper_threshold_low;
	logic [7:0] next_upper_threshold_high;
	logic [7:0] next_lower_threshold_low;
	logic [7:0] next_lower_threshold_high;
	logic [7:0] next_dwell_count_low;
	logic [7:0] next_dwell_count_high;
	// Write channel state and captured address and data.
	write_state_e write_state;
	write_state_e next_write_state;
	logic aw_held;
	logic next_aw_held;
	logic w_held;
	logic next_w_held;
	logic [11:0] aw_index;
	logic [11:0] next_aw_index;
	logic [7:0] w_byte;
	logic [7:0] next_w_byte;
	logic w_lane;
	logic next_w_lane;
	logic [1:0] bresp;
	logic [1:0] next_bresp;
	// Read channel state.
	read_state_e read_state;
	read_state_e next_read_state;
	logic [31:0] rdata;
	logic [31:0] next_rdata;
	logic [1:0] rresp;
	logic [1:0] next_rresp;
	// Detection path.
	magnitude_t upper_threshold;
	magnitude_t lower_threshold;
	dwell_t dwell_load;
	logic above_upper;
	logic below_lower;
	logic alarm;
	dwell_t dwell_count;
	logic next_pin;
	logic pin;

	// Thresholds and dwell load assembled from their byte registers.
	assign upper_threshold = {upper_threshold_high[4:0], upper_threshold_low};
	assign lower_threshold = {lower_threshold_high[4:0], lower_threshold_low};
	assign dwell_load = {dwell_count_high, dwell_count_low};
	assign above_upper = MAGNITUDE > upper_threshold;
	assign below_lower = MAGNITUDE < lower_threshold;

	// Timer that holds the alarm through the dwell time.
	dwell_timer timer
	(
		.clk(CLK),
		.rst(RST),
		.ce(CE),
		.active(detect_pin_control[`CTRL_ENABLE_BIT]),
		.above_upper(above_upper),
		.below_lower(below_lower),
		.load_value(dwell_load),
		.alarm(alarm),
		.count(dwell_count)
	);

	// Selects the pin level: forced value, detection result, or low when disabled.
	always_comb
	begin
		if (detect_pin_control[`CTRL_FORCE_BIT])
		begin
			// Override drives the software level.
			next_pin = detect_pin_control[`CTRL_FORCE_VALUE_BIT];
		end
		else if (detect_pin_control[`CTRL_ENABLE_BIT])
		begin
			// Normal operation follows the timer.
			next_pin = alarm;
		end
		else
		begin
			// Disabled output stays low.
			next_pin = 1'b0;
		end
	end

	// Registers the pin level.
	always_ff @(posedge CLK)
	begin
		if (RST)
		begin
			pin <= 1'b0;
		end
		else if (CE)
		begin
			pin <= next_pin;
		end
	end

	// Write channel: takes address and data in either order, then answers.
	always_comb
	begin
		next_write_state = write_state;
		next_aw_held = aw_held;
		next_w_held = w_held;
		next_aw_index = aw_index;
		next_w_byte = w_byte;
		next_w_lane = w_lane;
		next_bresp = bresp;
		next_detect_pin_control = detect_pin_control;
		next_upper_threshold_low = upper_threshold_low;
		next_upper_threshold_high = upper_threshold_high;
		next_lower_threshold_low = lower_threshold_low;
		next_lower_threshold_high = lower_threshold_high;
		next_dwell_count_low = dwell_count_low;
		next_dwell_count_high = dwell_count_high;
		unique case (write_state)
			WR_IDLE:
			begin
				// Capture whichever halves arrive.
				if (S_AXI_AWVALID && !aw_held)
				begin
					next_aw_held = 1'b1;
					next_aw_index = S_AXI_AWADDR[13:2];
				end
				if (S_AXI_WVALID && !w_held)
				begin
					next_w_held = 1'b1;
					next_w_byte = S_AXI_WDATA[7:0];
					next_w_lane = S_AXI_WSTRB[0];
				end
				// Both halves held: perform the write.
				if (aw_held && w_held)
				begin
					next_aw_held = 1'b0;
					next_w_held = 1'b0;
					next_write_state = WR_ANSWER;
					next_bresp = `RESP_OKAY;
					if (w_lane)
					begin
						unique case (aw_index)
							`IDX_DETECT_PIN_CONTROL:
								next_detect_pin_control = w_byte & `CTRL_WRITE_MASK;
							`IDX_UPPER_THRESHOLD_LOW:
								next_upper_threshold_low = w_byte;
							`IDX_UPPER_THRESHOLD_HIGH:
								next_upper_threshold_high = w_byte & `THRESHOLD_HIGH_MASK;
							`IDX_LOWER_THRESHOLD_LOW:
								next_lower_threshold_low = w_byte;
							`IDX_LOWER_THRESHOLD_HIGH:
								next_lower_threshold_high = w_byte & `THRESHOLD_HIGH_MASK;
							`IDX_DWELL_COUNT_LOW:
								next_dwell_count_low = w_byte;
							`IDX_DWELL_COUNT_HIGH:
								next_dwell_count_high = w_byte;
							`IDX_DETECT_STATUS:
								next_bresp = `RESP_OKAY;
							default:
								next_bresp = `RESP_SLVERR;
						endcase
					end
				end
			end
			WR_ANSWER:
			begin
				// Hold the response until the master takes it.
				if (S_AXI_BREADY)
				begin
					next_write_state = WR_IDLE;
				end
			end
		endcase
	end

	// Registers the write channel and the software registers.
	always_ff @(posedge CLK)
	begin
		if (RST)
		begin
			write_state <= WR_IDLE;
			aw_held <= 1'b0;
			w_held <= 1'b0;
			aw_index <= 12'h000;
			w_byte <= 8'h00;
			w_lane <= 1'b0;
			bresp <= `RESP_OKAY;
			detect_pin_control <= `FIELD_RESET;
			upper_threshold_low <= `FIELD_RESET;
			upper_threshold_high <= `FIELD_RESET;
			lower_threshold_low <= `FIELD_RESET;
			lower_threshold_high <= `FIELD_RESET;
			dwell_count_low <= `FIELD_RESET;
			dwell_count_high <= `FIELD_RESET;
		end
		else if (CE)
		begin
			write_state <= next_write_state;
			aw_held <= next_aw_held;
			w_held <= next_w_held;
			aw_index <= next_aw_index;
			w_byte <= next_w_byte;
			w_lane <= next_w_lane;
			bresp <= next_bresp;
			detect_pin_control <= next_detect_pin_control;
			upper_threshold_low <= next_upper_threshold_low;
			upper_threshold_high <= next_upper_threshold_high;
			lower_threshold_low <= next_lower_threshold_low;
			lower_threshold_high <= next_lower_threshold_high;
			dwell_count_low <= next_dwell_count_low;
			dwell_count_high <= next_dwell_count_high;
		end
	end

	// Read channel: one address, then one answer held until taken.
	always_comb
	begin
		next_read_state = read_state;
		next_rdata = rdata;
		next_rresp = rresp;
		unique case (read_state)
			RD_IDLE:
			begin
				if (S_AXI_ARVALID)
				begin
					next_read_state = RD_ANSWER;
					next_rresp = `RESP_OKAY;
					next_rdata = 32'h00000000;
					unique case (S_AXI_ARADDR[13:2])
						`IDX_DETECT_PIN_CONTROL:
							next_rdata[7:0] = detect_pin_control;
						`IDX_UPPER_THRESHOLD_LOW:
							next_rdata[7:0] = upper_threshold_low;
						`IDX_UPPER_THRESHOLD_HIGH:
							next_rdata[7:0] = upper_threshold_high;
						`IDX_LOWER_THRESHOLD_LOW:
							next_rdata[7:0] = lower_threshold_low;
						`IDX_LOWER_THRESHOLD_HIGH:
							next_rdata[7:0] = lower_threshold_high;
						`IDX_DWELL_COUNT_LOW:
							next_rdata[7:0] = dwell_count_low;
						`IDX_DWELL_COUNT_HIGH:
							next_rdata[7:0] = dwell_count_high;
						`IDX_DETECT_STATUS:
							next_rdata[16:0] = {pin, dwell_count};
						default:
							next_rresp = `RESP_SLVERR;
					endcase
				end
			end
			RD_ANSWER:
			begin
				// Hold data until the master takes it.
				if (S_AXI_RREADY)
				begin
					next_read_state = RD_IDLE;
				end
			end
		endcase
	end

	// Registers the read channel.
	always_ff @(posedge CLK)
	begin
		if (RST)
		begin
			read_state <= RD_IDLE;
			rdata <= 32'h00000000;
			rresp <= `RESP_OKAY;
		end
		else if (CE)
		begin
			read_state <= next_read_state;
			rdata <= next_rdata;
			rresp <= next_rresp;
		end
	end

	// Bus handshake outputs derived from flip-flop state, with the readies also gated by CE.
	assign S_AXI_AWREADY = (write_state == WR_IDLE) && !aw_held && CE;
	assign S_AXI_WREADY = (write_state == WR_IDLE) && !w_held && CE;
	assign S_AXI_BVALID = write_state == WR_ANSWER;
	assign S_AXI_BRESP = bresp;
	assign S_AXI_ARREADY = (read_state == RD_IDLE) && CE;
	assign S_AXI_RVALID = read_state == RD_ANSWER;
	assign S_AXI_RDATA = rdata;
	assign S_AXI_RRESP = rresp;
	assign LEVEL_ALARM_PIN = pin;
endmodule : level_alarm_monitor
`default_nettype wire

// [bench/gain_watcher.sv]
`default_nettype none
// Stand-in for the gain control logic that watches the alarm pin.
module gain_watcher
(
	input wire logic clk,
	input wire logic pin,
	output int rises
);
	timeunit 1ns;
	timeprecision 1ps;
	// Pin level at the previous edge.
	logic seen = 1'b0;
	initial rises = 0;
	// Count each onset of the alarm, as a gain stage would react to it.
	// The pin is looked at on the falling edge, where the registered level has settled.
	always @(negedge clk)
	begin
		seen <= pin;
		if (pin === 1'b1 && seen === 1'b0)
			rises <= rises + 1;
	end
endmodule : gain_watcher
`default_nettype wire

// [bench/level_alarm_properties.sv]
`include "level_alarm_regs.svh"
`default_nettype none
// Port-level checks; register copies are rebuilt from completed bus writes.
module level_alarm_properties
(
	input wire logic CLK,
	input wire logic RST,
	input wire logic CE,
	input wire logic [12:0] MAGNITUDE,
	input wire logic LEVEL_ALARM_PIN,
	input wire logic [13:0] S_AXI_AWADDR,
	input wire logic S_AXI_AWVALID,
	input wire logic S_AXI_AWREADY,
	input wire logic [31:0] S_AXI_WDATA,
	input wire logic [3:0] S_AXI_WSTRB,
	input wire logic S_AXI_WVALID,
	input wire logic S_AXI_WREADY,
	input wire logic [1:0] S_AXI_BRESP,
	input wire logic S_AXI_BVALID,
	input wire logic S_AXI_BREADY,
	input wire logic S_AXI_ARVALID,
	input wire logic S_AXI_ARREADY,
	input wire logic [31:0] S_AXI_RDATA,
	input wire logic S_AXI_RVALID,
	input wire logic S_AXI_RREADY
);
	logic [13:0] wa;
	logic [7:0] wd;
	logic ws;
	logic [7:0] ctl;
	logic [7:0] ul;
	logic [7:0] uh;
	logic [12:0] up;
	assign up = {uh[4:0], ul};
	// The copies lag the real registers by one edge, as the pin does.
	always_ff @(posedge CLK)
	begin
		if (RST)
		begin
			ctl <= 8'h00;
			ul <= 8'h00;
			uh <= 8'h00;
		end
		else
		begin
			// Handshakes are taken from values sampled before the edge, since readies and valids change on it.
			if ($sampled(S_AXI_AWVALID && S_AXI_AWREADY))
				wa <= $sampled(S_AXI_AWADDR);
			if ($sampled(S_AXI_WVALID && S_AXI_WREADY))
				wd <= $sampled(S_AXI_WDATA[7:0]);
			if ($sampled(S_AXI_WVALID && S_AXI_WREADY))
				ws <= $sampled(S_AXI_WSTRB[0]);
			if ($sampled(S_AXI_BVALID && S_AXI_BREADY && CE) && ws && wa == {`IDX_DETECT_PIN_CONTROL, 2'h0})
				ctl <= wd & `CTRL_WRITE_MASK;
			if ($sampled(S_AXI_BVALID && S_AXI_BREADY && CE) && ws && wa == {`IDX_UPPER_THRESHOLD_LOW, 2'h0})
				ul <= wd;
			if ($sampled(S_AXI_BVALID && S_AXI_BREADY && CE) && ws && wa == {`IDX_UPPER_THRESHOLD_HIGH, 2'h0})
				uh <= wd;
		end
	end
	default clocking cb @(posedge CLK);
	endclocking
	default disable iff (RST);
	a_pin_off: assert property (!ctl[0] && !ctl[3] |-> !LEVEL_ALARM_PIN)
		else $error("pin high while disabled");
	a_pin_forced: assert property (ctl[3] |-> LEVEL_ALARM_PIN == ctl[2])
		else $error("forced pin level wrong");
	a_pin_rise: assert property (CE && ctl[0] && !ctl[3] && MAGNITUDE > up ##1 CE && ctl[0] && !ctl[3] && $stable(up)
		##1 ctl[0] && !ctl[3] |-> LEVEL_ALARM_PIN)
		else $error("pin late above upper");
	a_reset_clear: assert property ($fell(RST) |-> !LEVEL_ALARM_PIN && !S_AXI_BVALID && !S_AXI_RVALID)
		else $error("outputs not cleared by reset");
	a_bresp_hold: assert property (S_AXI_BVALID && !(S_AXI_BREADY && CE) |=> S_AXI_BVALID && $stable(S_AXI_BRESP))
		else $error("write response dropped");
	a_rdata_hold: assert property (S_AXI_RVALID && !(S_AXI_RREADY && CE) |=> S_AXI_RVALID && $stable(S_AXI_RDATA))
		else $error("read data dropped");
	a_read_answer: assert property (S_AXI_ARVALID && S_AXI_ARREADY |=> S_AXI_RVALID)
		else $error("read not answered");
	a_write_done: assert property (S_AXI_BVALID && S_AXI_BREADY && CE |=> !S_AXI_BVALID)
		else $error("write response repeated");
endmodule : level_alarm_properties
bind level_alarm_monitor level_alarm_properties u_level_alarm_properties (.*);
`default_nettype wire

// [bench/level_alarm_monitor_bench.sv]
`include "level_alarm_regs.svh"
`default_nettype none
// Self-checking bench: register table, detection, dwell, reset and override.
module level_alarm_monitor_bench;
	timeunit 1ns;
	timeprecision 1ps;
	// One register row: address, data written, value read back, response.
	typedef struct {logic [13:0] a; logic [7:0] d; logic [31:0] q; logic [1:0] r;} row_s;
	row_s rows [8] = '{
		'{{`IDX_DETECT_PIN_CONTROL, 2'h0}, 8'hF2, 32'h0, `RESP_OKAY},
		'{{`IDX_UPPER_THRESHOLD_LOW, 2'h0}, 8'hA5, 32'hA5, `RESP_OKAY},
		'{{`IDX_UPPER_THRESHOLD_HIGH, 2'h0}, 8'hFF, 32'h1F, `RESP_OKAY},
		'{{`IDX_LOWER_THRESHOLD_LOW, 2'h0}, 8'h5A, 32'h5A, `RESP_OKAY},
		'{{`IDX_LOWER_THRESHOLD_HIGH, 2'h0}, 8'hE3, 32'h03, `RESP_OKAY},
		'{{`IDX_DWELL_COUNT_LOW, 2'h0}, 8'h96, 32'h96, `RESP_OKAY},
		'{{`IDX_DWELL_COUNT_HIGH, 2'h0}, 8'h69, 32'h69, `RESP_OKAY},
		'{{12'h24E, 2'h0}, 8'h77, 32'h0, `RESP_SLVERR}};
	logic CLK = 1'b0;
	logic RST = 1'b1;
	logic CE = 1'b1;
	logic [12:0] MAGNITUDE = 13'h0;
	logic LEVEL_ALARM_PIN;
	logic [13:0] S_AXI_AWADDR = 14'h0;
	logic S_AXI_AWVALID = 1'b0;
	logic S_AXI_AWREADY;
	logic [31:0] S_AXI_WDATA = 32'h0;
	logic [3:0] S_AXI_WSTRB = 4'hF;
	logic S_AXI_WVALID = 1'b0;
	logic S_AXI_WREADY;
	logic [1:0] S_AXI_BRESP;
	logic S_AXI_BVALID;
	logic S_AXI_BREADY = 1'b0;
	logic [13:0] S_AXI_ARADDR = 14'h0;
	logic S_AXI_ARVALID = 1'b0;
	logic S_AXI_ARREADY;
	logic [31:0] S_AXI_RDATA;
	logic [1:0] S_AXI_RRESP;
	logic S_AXI_RVALID;
	logic S_AXI_RREADY = 1'b0;
	int bad_count = 0;
	int checks_done = 0;
	int cycles = 0;
	int rises;
	logic [31:0] v;
	logic [1:0] r;
	level_alarm_monitor u_level_alarm_monitor
	(
		.CLK(CLK),
		.RST(RST),
		.CE(CE),
		.MAGNITUDE(MAGNITUDE),
		.LEVEL_ALARM_PIN(LEVEL_ALARM_PIN),
		.S_AXI_AWADDR(S_AXI_AWADDR),
		.S_AXI_AWVALID(S_AXI_AWVALID),
		.S_AXI_AWREADY(S_AXI_AWREADY),
		.S_AXI_WDATA(S_AXI_WDATA),
		.S_AXI_WSTRB(S_AXI_WSTRB),
		.S_AXI_WVALID(S_AXI_WVALID),
		.S_AXI_WREADY(S_AXI_WREADY),
		.S_AXI_BRESP(S_AXI_BRESP),
		.S_AXI_BVALID(S_AXI_BVALID),
		.S_AXI_BREADY(S_AXI_BREADY),
		.S_AXI_ARADDR(S_AXI_ARADDR),
		.S_AXI_ARVALID(S_AXI_ARVALID),
		.S_AXI_ARREADY(S_AXI_ARREADY),
		.S_AXI_RDATA(S_AXI_RDATA),
		.S_AXI_RRESP(S_AXI_RRESP),
		.S_AXI_RVALID(S_AXI_RVALID),
		.S_AXI_RREADY(S_AXI_RREADY)
	);
	gain_watcher u_gain_watcher (.clk(CLK), .pin(LEVEL_ALARM_PIN), .rises(rises));
	always #10 CLK = ~CLK;
	task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
		checks_done++;
		if (g !== e)
		begin
			bad_count++;
			$display("unexpected %s: expected %h, seen %h", n, e, g);
		end
	endtask : chk
	// Write: both channels offered together, each dropped once taken.
	task automatic wr(input logic [13:0] a, input logic [7:0] d, output logic [1:0] rs);
		logic aw;
		logic w;
		aw = 1'b0;
		w = 1'b0;
		@(posedge CLK);
		S_AXI_AWADDR <= a;
		S_AXI_WDATA <= {24'h0, d};
		S_AXI_AWVALID <= 1'b1;
		S_AXI_WVALID <= 1'b1;
		S_AXI_BREADY <= 1'b1;
		while (!(aw && w))
		begin
			// Readies are looked at before the edge that takes them, where they have settled.
			@(negedge CLK);
			aw = aw | (S_AXI_AWVALID && S_AXI_AWREADY);
			w = w | (S_AXI_WVALID && S_AXI_WREADY);
			@(posedge CLK);
			S_AXI_AWVALID <= !aw;
			S_AXI_WVALID <= !w;
		end
		do @(negedge CLK); while (S_AXI_BVALID !== 1'b1);
		rs = S_AXI_BRESP;
		@(posedge CLK);
		S_AXI_BREADY <= 1'b0;
	endtask : wr
	task automatic rd(input logic [13:0] a, output logic [31:0] q, output logic [1:0] rs);
		@(posedge CLK);
		S_AXI_ARADDR <= a;
		S_AXI_ARVALID <= 1'b1;
		S_AXI_RREADY <= 1'b1;
		do @(negedge CLK); while (S_AXI_ARREADY !== 1'b1);
		@(posedge CLK);
		S_AXI_ARVALID <= 1'b0;
		do @(negedge CLK); while (S_AXI_RVALID !== 1'b1);
		q = S_AXI_RDATA;
		rs = S_AXI_RRESP;
		@(posedge CLK);
		S_AXI_RREADY <= 1'b0;
	endtask : rd
	task automatic put(input logic [11:0] i, input logic [7:0] d);
		wr({i, 2'h0}, d, r);
		chk("write response", `RESP_OKAY, r);
	endtask : put
	task automatic run(input int n);
		repeat (n) @(posedge CLK);
	endtask : run
	task automatic end_of_test();
		$display("checks %0d, mismatches %0d", checks_done, bad_count);
		if (bad_count == 0 && checks_done > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask : end_of_test
	// A hang counts as a mismatch.
	always @(posedge CLK)
	begin
		cycles++;
		if (cycles == 5000)
		begin
			bad_count++;
			end_of_test();
		end
	end
	initial
	begin
		run(6);
		RST <= 1'b0;
		for (int i = 0; i < 7; i++)
		begin
			rd(rows[i].a, v, r);
			chk("reset value", 32'h0, v);
		end
		for (int i = 0; i < 8; i++)
		begin
			wr(rows[i].a, rows[i].d, r);
			chk("write response", rows[i].r, r);
			rd(rows[i].a, v, r);
			chk("read response", rows[i].r, r);
			if (r === `RESP_OKAY)
				chk("read data", rows[i].q, v);
		end
		chk("pin", 1'b0, LEVEL_ALARM_PIN);
		// A write with lane 0 switched off must leave the register as it was.
		S_AXI_WSTRB <= 4'h0;
		wr({`IDX_UPPER_THRESHOLD_LOW, 2'h0}, 8'h33, r);
		chk("masked write response", `RESP_OKAY, r);
		S_AXI_WSTRB <= 4'hF;
		rd({`IDX_UPPER_THRESHOLD_LOW, 2'h0}, v, r);
		chk("masked write", 32'hA5, v);
		$display("test register table done");
		put(`IDX_UPPER_THRESHOLD_LOW, 8'h0A);
		put(`IDX_UPPER_THRESHOLD_HIGH, 8'h00);
		put(`IDX_LOWER_THRESHOLD_LOW, 8'h05);
		put(`IDX_LOWER_THRESHOLD_HIGH, 8'h00);
		put(`IDX_DWELL_COUNT_LOW, 8'h03);
		put(`IDX_DWELL_COUNT_HIGH, 8'h01);
		put(`IDX_DETECT_PIN_CONTROL, 8'h01);
		MAGNITUDE <= 13'h000A;
		run(6);
		chk("pin at upper", 1'b0, LEVEL_ALARM_PIN);
		MAGNITUDE <= 13'h000B;
		run(3);
		chk("pin above upper", 1'b1, LEVEL_ALARM_PIN);
		MAGNITUDE <= 13'h0005;
		run(300);
		chk("pin at lower", 1'b1, LEVEL_ALARM_PIN);
		MAGNITUDE <= 13'h0004;
		run(200);
		MAGNITUDE <= 13'h0005;
		run(1);
		MAGNITUDE <= 13'h0004;
		run(259);
		chk("pin in dwell", 1'b1, LEVEL_ALARM_PIN);
		run(8);
		chk("pin after dwell", 1'b0, LEVEL_ALARM_PIN);
		$display("test detection done");
		MAGNITUDE <= 13'h000B;
		run(4);
		RST <= 1'b1;
		run(2);
		RST <= 1'b0;
		chk("pin after reset", 1'b0, LEVEL_ALARM_PIN);
		rd({`IDX_UPPER_THRESHOLD_LOW, 2'h0}, v, r);
		chk("upper after reset", 32'h0, v);
		run(4);
		chk("pin disabled", 1'b0, LEVEL_ALARM_PIN);
		MAGNITUDE <= 13'h0000;
		put(`IDX_DETECT_PIN_CONTROL, 8'h01);
		CE <= 1'b0;
		MAGNITUDE <= 13'h000B;
		run(5);
		CE <= 1'b1;
		run(3);
		chk("pin after pause", 1'b1, LEVEL_ALARM_PIN);
		$display("test reset and enable done");
		put(`IDX_DETECT_PIN_CONTROL, 8'h09);
		run(2);
		chk("forced low", 1'b0, LEVEL_ALARM_PIN);
		put(`IDX_DETECT_PIN_CONTROL, 8'h0D);
		run(2);
		chk("forced high", 1'b1, LEVEL_ALARM_PIN);
		chk("alarm onsets", 32'd4, rises);
		// Status shows the forced pin in bit 16; the dwell count sits at its zero load.
		rd({`IDX_DETECT_STATUS, 2'h0}, v, r);
		chk("status word", 32'h00010000, v);
		$display("test override done");
		end_of_test();
	end
endmodule : level_alarm_monitor_bench
`default_nettype wire
